// ---- core/usc_defs.vh ----
// What this block does
// RULE_01: Host waits for synchronised link-up bit zero.
// RULE_02: Common settings shared; session settings kept per session.
// RULE_03: Host keeps old value when input invalid.
// RULE_04: Sixteen sessions, handled in ascending order.
// RULE_05: Host writes common, session settings, enable last.
// RULE_06: Active mask equals enable after init/shutdown.
// RULE_07: Host polls active until it equals enable.
// RULE_08: Common change needs all sessions disabled first.
// RULE_09: Host writes zero enable for common update.
// RULE_10: Session change clears only that enable bit.
// RULE_11: Host waits for match before rewriting settings.
// RULE_12: Enable bit set starts that session's initialisation.
// RULE_13: Test needs at least one enabled session.
// RULE_14: Total size and check flag shared; invalid cancels.
// RULE_15: Checker compares incrementing 32-bit words from seed.
// RULE_16: Command 1 runs unchecked, 3 runs checked.
// RULE_17: Host starts timer on first non-zero count.
// RULE_18: Session done on 100 ms idle or total.
// RULE_19: Error flags split sessions 0-7 and 8-15.
// RULE_20: Two latency readouts: receive cores, bus adapter.
// RULE_21: Mask bit n belongs to session n.
`ifndef USC_DEFS_VH
`define USC_DEFS_VH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define USC_CLK_PERIOD_NS   100
`define USC_INIT_TIME_NS    2000
`define USC_SHUT_TIME_NS    1000
`define USC_INIT_CYCLES     ((`USC_INIT_TIME_NS + `USC_CLK_PERIOD_NS - 1) / `USC_CLK_PERIOD_NS)
`define USC_SHUT_CYCLES     ((`USC_SHUT_TIME_NS + `USC_CLK_PERIOD_NS - 1) / `USC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Sizes and codes
// ----------------------------------------------------------------------
`define USC_SESSIONS        16
`define USC_BYTES_PER_WORD  64'h0000000000000004
`define USC_CMD_RUN         2'h1
`define USC_CMD_RUN_CHECK   2'h3
`define USC_CMD_RUN_BIT     0
`define USC_CMD_CHECK_BIT   1
`define USC_LINK_UP_BIT     0
`define USC_LAT_RESET       16'h0000

`endif

// ---- core/usc_session_ctl.v ----
`timescale 1ns/100ps
`include "usc_defs.vh"

// ----------------------------------------------------------------------
// Per-session bring-up and shutdown sequencer
// ----------------------------------------------------------------------
module usc_session_ctl #(
  parameter INIT_CYCLES = `USC_INIT_CYCLES,
  parameter SHUT_CYCLES = `USC_SHUT_CYCLES,
  parameter CW          = 8
) (
  // Clock and reset.
  input  wire clk,
  input  wire arst_n,
  // Enable bit of this session.
  input  wire enable,
  // Active flag of this session.
  output reg  active
);

  // One-hot state codes.
  localparam [3:0] ST_OFF  = 4'h1;
  localparam [3:0] ST_INIT = 4'h2;
  localparam [3:0] ST_ON   = 4'h4;
  localparam [3:0] ST_SHUT = 4'h8;

  // Last count of each timed state, cut to the counter width on purpose.
  localparam integer  INIT_END  = INIT_CYCLES - 1;
  localparam integer  SHUT_END  = SHUT_CYCLES - 1;
  localparam [CW-1:0] INIT_LAST = INIT_END[CW-1:0];
  localparam [CW-1:0] SHUT_LAST = SHUT_END[CW-1:0];

  reg [3:0]    state;       // Current state.
  reg [3:0]    next_state;  // State for the next edge.
  reg [CW-1:0] cnt;         // Cycles spent in the timed state.

  // Next-state decision; a session dropped mid-bring-up still shuts down
  // fully so the active flag never clears before resources are released.
  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (enable) begin
          next_state = ST_INIT; // RULE_12
        end
      end
      ST_INIT: begin
        if (!enable) begin
          next_state = ST_SHUT;
        end else if (cnt == INIT_LAST) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (!enable) begin
          next_state = ST_SHUT;
        end
      end
      ST_SHUT: begin
        if (cnt == SHUT_LAST) begin
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // State, timer and active flag; active covers the shutdown phase so a
  // cleared enable bit only matches once the session is really idle.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= ST_OFF;
      cnt    <= {CW{1'b0}};
      active <= 1'b0;
    end else begin
      state  <= next_state;
      if (next_state != state) begin
        cnt <= {CW{1'b0}};
      end else begin
        cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
      end
      active <= (next_state == ST_ON) || (next_state == ST_SHUT); // RULE_06
    end
  end

endmodule // usc_session_ctl

// ---- core/usc_top.v ----
`timescale 1ns/100ps
`include "usc_defs.vh"

// ----------------------------------------------------------------------
// Sixteen-session receive subsystem: settings, session control, checker
// ----------------------------------------------------------------------
module usc_top #(
  parameter NSES        = `USC_SESSIONS,
  parameter INIT_CYCLES = `USC_INIT_CYCLES,
  parameter SHUT_CYCLES = `USC_SHUT_CYCLES
) (
  // Clock and reset.
  input  wire        REF_CLK,
  input  wire        ARST_N,
  // Link pin and its synchronised status.
  input  wire        LINK_UP,
  output reg  [0:0]  LINK_STATUS,
  // Common settings.
  input  wire        COMMON_WR,
  input  wire        GROUP_MODE,
  input  wire [47:0] LOCAL_MAC,
  input  wire [31:0] LOCAL_IP,
  // Session settings write port.
  input  wire        SES_WR,
  input  wire [3:0]  SES_SEL,
  input  wire [15:0] SES_LOCAL_PORT,
  input  wire [15:0] SES_REMOTE_PORT,
  input  wire [31:0] SES_REMOTE_IP,
  input  wire [31:0] SES_GROUP_IP,
  // Session settings readback.
  output reg         CUR_GROUP_MODE,
  output reg  [15:0] CUR_LOCAL_PORT,
  output reg  [31:0] CUR_REMOTE_IP,
  // Session enable and active masks.
  input  wire [15:0] SESSION_ENABLE,
  output wire [15:0] SESSION_ACTIVE,
  // Start pattern write port.
  input  wire        PAT_WR,
  input  wire [3:0]  PAT_SEL,
  input  wire [31:0] PAT_VALUE,
  // Checker command.
  input  wire        CMD_WR,
  input  wire [1:0]  CMD_VALUE,
  output reg         RUNNING,
  // Received data words from the adapter.
  input  wire        RX_VALID,
  input  wire [3:0]  RX_SESSION,
  input  wire [31:0] RX_DATA,
  // Latency markers.
  input  wire        FRAME_IN,
  input  wire        CORE_OUT,
  // Byte counter readback.
  input  wire [3:0]  CNT_SEL,
  output reg  [31:0] CNT_LOW,
  output reg  [31:0] CNT_HIGH,
  // Error flags and latency readouts.
  output reg  [7:0]  ERR_LOW,
  output reg  [7:0]  ERR_HIGH,
  output reg  [15:0] RX_CORE_LATENCY,
  output reg  [15:0] ADAPTER_LATENCY
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Decodes a session number into its mask bit.
  function [15:0] sel_bit;
    input [3:0] sel;
    begin
      sel_bit = 16'h0001 << sel; // RULE_21
    end
  endfunction

  // Saturating latency step, so a missing end marker cannot wrap to a
  // small, believable figure.
  function [15:0] sat_inc;
    input [15:0] v;
    begin
      sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Link status synchroniser
  // ----------------------------------------------------------------------
  reg link_s1; // First stage, read only by the second.
  reg link_s2; // Second stage.
  reg link_s3; // Third stage.

  // The status follows only once the last two stages agree.
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      link_s1     <= 1'b0;
      link_s2     <= 1'b0;
      link_s3     <= 1'b0;
      LINK_STATUS <= 1'b0;
    end else begin
      link_s1 <= LINK_UP;
      link_s2 <= link_s1;
      link_s3 <= link_s2;
      if (link_s2 == link_s3) begin
        LINK_STATUS[`USC_LINK_UP_BIT] <= link_s3; // RULE_01
      end
    end
  end

  // ----------------------------------------------------------------------
  // Settings storage
  // ----------------------------------------------------------------------
  reg        group_mode;               // Shared addressing mode.
  reg [47:0] local_mac;                // Shared local MAC.
  reg [31:0] local_ip;                 // Shared local IP.
  reg [15:0] local_port  [0:NSES-1];   // Per-session local port.
  reg [15:0] remote_port [0:NSES-1];   // Per-session remote port.
  reg [31:0] remote_ip   [0:NSES-1];   // Per-session remote IP.
  reg [31:0] group_ip    [0:NSES-1];   // Per-session group IP.
  reg [31:0] start_pat   [0:NSES-1];   // Per-session checker seed.
  integer    i;                        // Loop index of the settings process.
  integer    k;                        // Loop index of the checker process.

  // Common settings apply to every session at once; per-session entries
  // are independent and addressed by session number.
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      group_mode <= 1'b0;
      local_mac  <= 48'h000000000000;
      local_ip   <= 32'h00000000;
      for (i = 0; i < NSES; i = i + 1) begin
        local_port[i]  <= 16'h0000;
        remote_port[i] <= 16'h0000;
        remote_ip[i]   <= 32'h00000000;
        group_ip[i]    <= 32'h00000000;
        start_pat[i]   <= 32'h00000000;
      end
    end else begin
      if (COMMON_WR) begin
        group_mode <= GROUP_MODE; // RULE_02
        local_mac  <= LOCAL_MAC;
        local_ip   <= LOCAL_IP;
      end
      if (SES_WR) begin
        local_port[SES_SEL]  <= SES_LOCAL_PORT; // RULE_02
        remote_port[SES_SEL] <= SES_REMOTE_PORT;
        remote_ip[SES_SEL]   <= SES_REMOTE_IP;
        group_ip[SES_SEL]    <= SES_GROUP_IP;
      end
      if (PAT_WR) begin
        start_pat[PAT_SEL] <= PAT_VALUE; // RULE_15
      end
    end
  end

  // Readback of the stored settings of the selected session.
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CUR_GROUP_MODE <= 1'b0;
      CUR_LOCAL_PORT <= 16'h0000;
      CUR_REMOTE_IP  <= 32'h00000000;
    end else begin
      CUR_GROUP_MODE <= group_mode;
      CUR_LOCAL_PORT <= local_port[SES_SEL];
      CUR_REMOTE_IP  <= remote_ip[SES_SEL];
    end
  end

  // ----------------------------------------------------------------------
  // Session sequencers, one per session in ascending order
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NSES; g = g + 1) begin : ses
      usc_session_ctl #(
        .INIT_CYCLES (INIT_CYCLES),
        .SHUT_CYCLES (SHUT_CYCLES),
        .CW          (8)
      ) u_ctl (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .enable (SESSION_ENABLE[g]), // RULE_04
        .active (SESSION_ACTIVE[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Data checker and byte counters
  // ----------------------------------------------------------------------
  reg        check_en;                // Pattern comparison on.
  reg [31:0] expect_word [0:NSES-1];  // Next expected word per session.
  reg [63:0] byte_cnt    [0:NSES-1];  // Received bytes per session.
  reg [15:0] err_flags;               // Sticky mismatch flags.
  wire       rx_take;                 // Word accepted for counting.

  assign rx_take = RUNNING && RX_VALID && ((SESSION_ACTIVE & sel_bit(RX_SESSION)) != 16'h0000);

  // A start command reseeds and clears everything; words arriving in the
  // start cycle are dropped since the seeds are being loaded then.
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RUNNING   <= 1'b0;
      check_en  <= 1'b0;
      err_flags <= 16'h0000;
      for (k = 0; k < NSES; k = k + 1) begin
        expect_word[k] <= 32'h00000000;
        byte_cnt[k]    <= 64'h0000000000000000;
      end
    end else if (CMD_WR) begin
      RUNNING   <= CMD_VALUE[`USC_CMD_RUN_BIT]; // RULE_16
      check_en  <= (CMD_VALUE == `USC_CMD_RUN_CHECK); // RULE_16
      err_flags <= 16'h0000;
      for (k = 0; k < NSES; k = k + 1) begin
        expect_word[k] <= start_pat[k]; // RULE_15
        byte_cnt[k]    <= 64'h0000000000000000;
      end
    end else if (rx_take) begin
      byte_cnt[RX_SESSION]    <= byte_cnt[RX_SESSION] + `USC_BYTES_PER_WORD;
      expect_word[RX_SESSION] <= expect_word[RX_SESSION] + 32'h00000001; // RULE_15
      if (check_en && (RX_DATA != expect_word[RX_SESSION])) begin
        err_flags <= err_flags | sel_bit(RX_SESSION); // RULE_15
      end
    end
  end

  // Registered readouts of counters and error flags.
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CNT_LOW  <= 32'h00000000;
      CNT_HIGH <= 32'h00000000;
      ERR_LOW  <= 8'h00;
      ERR_HIGH <= 8'h00;
    end else begin
      CNT_LOW  <= byte_cnt[CNT_SEL][31:0];
      CNT_HIGH <= byte_cnt[CNT_SEL][63:32];
      ERR_LOW  <= err_flags[7:0];  // RULE_19
      ERR_HIGH <= err_flags[15:8]; // RULE_19
    end
  end

  // ----------------------------------------------------------------------
  // Latency measurement
  // ----------------------------------------------------------------------
  reg        core_busy;  // Frame inside the receive cores.
  reg        adapt_busy; // Frame inside the adapter.
  reg [15:0] core_cnt;   // Cycles since the frame entered.
  reg [15:0] adapt_cnt;  // Cycles since the cores handed it on.

  // Core latency runs from frame entry to core output; adapter latency
  // from core output to the first accepted word. Only one frame is timed
  // at a time, so a new entry marker mid-measurement is ignored.
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      core_busy       <= 1'b0;
      adapt_busy      <= 1'b0;
      core_cnt        <= `USC_LAT_RESET;
      adapt_cnt       <= `USC_LAT_RESET;
      RX_CORE_LATENCY <= `USC_LAT_RESET;
      ADAPTER_LATENCY <= `USC_LAT_RESET;
    end else begin
      if (core_busy && CORE_OUT) begin
        core_busy       <= 1'b0;
        RX_CORE_LATENCY <= core_cnt; // RULE_20
        adapt_busy      <= 1'b1;
        adapt_cnt       <= 16'h0001;
      end else if (core_busy) begin
        core_cnt <= sat_inc(core_cnt);
      end else if (FRAME_IN && !adapt_busy) begin
        core_busy <= 1'b1;
        core_cnt  <= 16'h0001;
      end
      if (adapt_busy && rx_take) begin
        adapt_busy      <= 1'b0;
        ADAPTER_LATENCY <= adapt_cnt; // RULE_20
      end else if (adapt_busy) begin
        adapt_cnt <= sat_inc(adapt_cnt);
      end
    end
  end

endmodule // usc_top

// ---- testbench/usc_checker_asserts.sv ----
`timescale 1ns/100ps
`include "usc_defs.vh"
// --------------------
// Session checker
// --------------------
module usc_checker #(
  parameter NSES        = `USC_SESSIONS,
  parameter INIT_CYCLES = `USC_INIT_CYCLES,
  parameter SHUT_CYCLES = `USC_SHUT_CYCLES
) (
  // Clock and reset.
  input wire        REF_CLK,
  input wire        ARST_N,
  // Link and session masks.
  input wire        LINK_UP,
  input wire [0:0]  LINK_STATUS,
  input wire [15:0] SESSION_ENABLE,
  input wire [15:0] SESSION_ACTIVE,
  // Run state and flags.
  input wire        CMD_WR,
  input wire [1:0]  CMD_VALUE,
  input wire        RUNNING,
  input wire [7:0]  ERR_LOW,
  input wire [7:0]  ERR_HIGH
);
  // Sampled edges after a seen mask edge during which the old state still shows.
  localparam int IC = INIT_CYCLES;
  localparam int SC = SHUT_CYCLES;
  // Both flag bytes as one word.
  wire [15:0] errs = {ERR_HIGH, ERR_LOW};

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  // A plain run start followed by a quiet stretch.
  sequence s_plain;
    CMD_WR && CMD_VALUE == 2'h1 ##1 !CMD_WR [*8];
  endsequence

  link_up_a: assert property (LINK_UP [*6] |-> LINK_STATUS[0])
    else $error("link status missed a steady link");
  link_down_a: assert property (!LINK_UP [*6] |-> !LINK_STATUS[0])
    else $error("link status kept a lost link");
  run_cmd_a: assert property (CMD_WR |=> RUNNING == $past(CMD_VALUE[0]))
    else $error("run flag does not follow the command");
  run_hold_a: assert property (!CMD_WR |=> $stable(RUNNING))
    else $error("run flag moved without a command");
  err_clear_a: assert property (CMD_WR |-> ##2 errs == 16'h0000)
    else $error("error flags not cleared by a command");
  err_unchecked_a: assert property (s_plain |-> errs == 16'h0000)
    else $error("error flag raised in an unchecked run");
  // Flags are sticky: once set, only a command may clear them.
  err_sticky_a: assert property (errs != 16'h0000 && !$past(CMD_WR) |=>
    (errs & $past(errs)) == $past(errs))
    else $error("error flag dropped without a command");

  // Each mask bit is its own session with its own timing.
  genvar i;
  for (i = 0; i < 16; i = i + 1) begin : g_ses
    sequence s_rise;
      $rose(SESSION_ENABLE[i]) && !SESSION_ACTIVE[i];
    endsequence
    sequence s_fall;
      $fell(SESSION_ENABLE[i]) && SESSION_ACTIVE[i];
    endsequence
    init_delay_a: assert property (s_rise |-> ##IC !SESSION_ACTIVE[i] ##1 SESSION_ACTIVE[i])
      else $error("session went active at the wrong cycle");
    shut_delay_a: assert property (s_fall |-> ##SC SESSION_ACTIVE[i] ##1 !SESSION_ACTIVE[i])
      else $error("session shut down at the wrong cycle");
    idle_off_a: assert property (!SESSION_ENABLE[i] && !$past(SESSION_ENABLE[i]) &&
      !$past(SESSION_ENABLE[i], 2) && !SESSION_ACTIVE[i] |=> !SESSION_ACTIVE[i])
      else $error("disabled session became active");
  end
endmodule // usc_checker

bind usc_top usc_checker #(
  .NSES(NSES), .INIT_CYCLES(INIT_CYCLES), .SHUT_CYCLES(SHUT_CYCLES)
) chk (
  .REF_CLK, .ARST_N, .LINK_UP, .LINK_STATUS, .SESSION_ENABLE, .SESSION_ACTIVE,
  .CMD_WR, .CMD_VALUE, .RUNNING, .ERR_LOW, .ERR_HIGH
);

// ---- testbench/usc_top_bench.sv ----
`timescale 1ns/100ps
// --------------------
// Session bench
// --------------------
module usc_top_bench;
  // Short counts keep the run brief; expectations follow them.
  localparam IC = 2;
  localparam SC = 2;
  // Stimulus.
  reg        REF_CLK, ARST_N, LINK_UP, COMMON_WR, GROUP_MODE;
  reg        SES_WR, PAT_WR, CMD_WR, RX_VALID, FRAME_IN, CORE_OUT;
  reg [47:0] LOCAL_MAC;
  reg [31:0] LOCAL_IP, SES_REMOTE_IP, SES_GROUP_IP, PAT_VALUE, RX_DATA;
  reg [15:0] SES_LOCAL_PORT, SES_REMOTE_PORT, SESSION_ENABLE;
  reg [3:0]  SES_SEL, PAT_SEL, RX_SESSION, CNT_SEL;
  reg [1:0]  CMD_VALUE;
  // Observed outputs.
  wire [0:0]  LINK_STATUS;
  wire        CUR_GROUP_MODE, RUNNING;
  wire [15:0] CUR_LOCAL_PORT, SESSION_ACTIVE, RX_CORE_LATENCY, ADAPTER_LATENCY;
  wire [31:0] CUR_REMOTE_IP, CNT_LOW, CNT_HIGH;
  wire [7:0]  ERR_LOW, ERR_HIGH;
  integer     num_errors, comparisons, i;

  usc_top #(.INIT_CYCLES(IC), .SHUT_CYCLES(SC)) uut (
    .REF_CLK, .ARST_N, .LINK_UP, .LINK_STATUS, .COMMON_WR, .GROUP_MODE,
    .LOCAL_MAC, .LOCAL_IP, .SES_WR, .SES_SEL, .SES_LOCAL_PORT,
    .SES_REMOTE_PORT, .SES_REMOTE_IP, .SES_GROUP_IP, .CUR_GROUP_MODE,
    .CUR_LOCAL_PORT, .CUR_REMOTE_IP, .SESSION_ENABLE, .SESSION_ACTIVE,
    .PAT_WR, .PAT_SEL, .PAT_VALUE, .CMD_WR, .CMD_VALUE, .RUNNING,
    .RX_VALID, .RX_SESSION, .RX_DATA, .FRAME_IN, .CORE_OUT, .CNT_SEL,
    .CNT_LOW, .CNT_HIGH, .ERR_LOW, .ERR_HIGH, .RX_CORE_LATENCY,
    .ADAPTER_LATENCY
  );

  // 10 MHz clock.
  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end

  // --------------------
  // Helpers
  // --------------------
  // Case equality, so an unknown never passes.
  task cmp(input string n, input [31:0] e, input [31:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge REF_CLK);
  endtask
  task summarize;
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Mask change at one edge; the active mask updates at the n-th edge after
  // it, so look one edge before and just after that update.
  task en_step(input [15:0] en, input integer n, input [15:0] a0, input [15:0] a1);
    @(posedge REF_CLK);
    SESSION_ENABLE <= en;
    tick(n - 1);
    #1;
    cmp("active_before", a0, SESSION_ACTIVE);
    tick(1);
    #1;
    cmp("active_after", a1, SESSION_ACTIVE);
  endtask
  // One-cycle strobes; back-to-back calls leave an edge between.
  task pat(input [3:0] s, input [31:0] v);
    @(posedge REF_CLK);
    {PAT_WR, PAT_SEL, PAT_VALUE} <= {1'b1, s, v};
    @(posedge REF_CLK);
    PAT_WR <= 1'b0;
  endtask
  task cmd(input [1:0] v);
    @(posedge REF_CLK);
    {CMD_WR, CMD_VALUE} <= {1'b1, v};
    @(posedge REF_CLK);
    CMD_WR <= 1'b0;
  endtask
  // Words are held back to back; idle drops the strobe.
  task word(input [3:0] s, input [31:0] d);
    @(posedge REF_CLK);
    {RX_VALID, RX_SESSION, RX_DATA} <= {1'b1, s, d};
  endtask
  task idle;
    @(posedge REF_CLK);
    RX_VALID <= 1'b0;
  endtask
  task cnt(input [3:0] s, input [31:0] e);
    @(posedge REF_CLK);
    CNT_SEL <= s;
    tick(2);
    #1;
    cmp("count_low", e, CNT_LOW);
    cmp("count_high", 32'h0, CNT_HIGH);
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task t_link;
    cmp("link_down", 32'h0, LINK_STATUS);
    LINK_UP <= 1'b1;
    tick(6);
    #1;
    cmp("link_up", 32'h1, LINK_STATUS);
    // A lost link must show too; the link then comes back for the rest.
    @(posedge REF_CLK);
    LINK_UP <= 1'b0;
    tick(6);
    #1;
    cmp("link_lost", 32'h0, LINK_STATUS);
    @(posedge REF_CLK);
    LINK_UP <= 1'b1;
    tick(6);
    #1;
    cmp("link_back", 32'h1, LINK_STATUS);
  endtask
  // Common write, then all sessions in ascending order, then readback.
  task t_settings;
    @(posedge REF_CLK);
    {COMMON_WR, GROUP_MODE, LOCAL_MAC, LOCAL_IP} <= {2'h3, 48'h0a0b0c0d0e0f, 32'hc0a80001};
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge REF_CLK);
      {COMMON_WR, SES_WR, SES_SEL} <= {2'h1, i[3:0]};
      SES_LOCAL_PORT <= 16'h1000 + i[15:0];
      SES_REMOTE_IP <= 32'hc0a80100 + i;
    end
    for (i = 0; i < 16; i = i + 1) begin
      @(posedge REF_CLK);
      {SES_WR, SES_SEL} <= {1'b0, i[3:0]};
      tick(2);
      #1;
      cmp("local_port", 32'h1000 + i, CUR_LOCAL_PORT);
      cmp("remote_ip", 32'hc0a80100 + i, CUR_REMOTE_IP);
    end
    cmp("group_mode", 32'h1, CUR_GROUP_MODE);
  endtask
  // Checked run: good words, a bad word in each flag byte, an idle session.
  task t_check;
    pat(4'h0, 32'h10);
    pat(4'h2, 32'h100);
    pat(4'h9, 32'h900);
    cmd(2'h3);
    #1;
    cmp("running", 32'h1, RUNNING);
    for (i = 0; i < 3; i = i + 1)
      word(4'h0, 32'h10 + i);
    word(4'h2, 32'h101);
    word(4'h1, 32'h500);
    word(4'h9, 32'h900);
    word(4'h9, 32'h902);
    idle;
    tick(2);
    #1;
    cmp("err_low", 32'h04, ERR_LOW);
    cmp("err_high", 32'h02, ERR_HIGH);
    cnt(4'h0, 32'hc);
    cnt(4'h1, 32'h0);
    cnt(4'h2, 32'h4);
    cnt(4'h9, 32'h8);
  endtask
  // Unchecked run with wrong data, latency markers, then a stop.
  task t_plain;
    cmd(2'h1);
    word(4'h0, 32'hdead);
    word(4'h0, 32'h0);
    idle;
    tick(3);
    #1;
    cmp("err_plain", 32'h0, {ERR_HIGH, ERR_LOW});
    cnt(4'h0, 32'h8);
    @(posedge REF_CLK);
    FRAME_IN <= 1'b1;
    @(posedge REF_CLK);
    FRAME_IN <= 1'b0;
    tick(3);
    CORE_OUT <= 1'b1;
    @(posedge REF_CLK);
    CORE_OUT <= 1'b0;
    tick(2);
    word(4'h0, 32'h1);
    idle;
    tick(2);
    #1;
    cmp("core_lat", 32'h4, RX_CORE_LATENCY);
    cmp("adapt_lat", 32'h4, ADAPTER_LATENCY);
    cmd(2'h0);
    #1;
    cmp("stopped", 32'h0, RUNNING);
  endtask
  // A common change goes through an all-off mask and back on.
  task t_common;
    en_step(16'h0000, SC + 1, 16'h0205, 16'h0000);
    @(posedge REF_CLK);
    {COMMON_WR, GROUP_MODE} <= 2'h2;
    @(posedge REF_CLK);
    COMMON_WR <= 1'b0;
    tick(2);
    #1;
    cmp("group_mode", 32'h0, CUR_GROUP_MODE);
    en_step(16'h8001, IC + 1, 16'h0000, 16'h8001);
  endtask

  // Main sequence.
  initial begin
    {ARST_N, LINK_UP, COMMON_WR, GROUP_MODE, SES_WR, PAT_WR} = 6'h00;
    {CMD_WR, RX_VALID, FRAME_IN, CORE_OUT, LOCAL_MAC, LOCAL_IP} = 84'h0;
    {SES_REMOTE_IP, SES_GROUP_IP, PAT_VALUE, RX_DATA} = 128'h0;
    {SES_LOCAL_PORT, SES_REMOTE_PORT, SESSION_ENABLE} = 48'h0;
    {SES_SEL, PAT_SEL, RX_SESSION, CNT_SEL, CMD_VALUE} = 18'h0;
    num_errors = 0;
    comparisons = 0;
    tick(8);
    ARST_N <= 1'b1;
    t_link;
    t_settings;
    en_step(16'h0207, IC + 1, 16'h0000, 16'h0207);
    en_step(16'h0205, SC + 1, 16'h0207, 16'h0205);
    t_check;
    t_plain;
    t_common;
    summarize;
  end

  // Watchdog: the tests need about a twelfth of this span.
  initial begin
    #200000;
    num_errors = num_errors + 1;
    summarize;
  end
endmodule // usc_top_bench
